// ==== rtl/ccms_regs.svh ====
// Purpose: constants for the cpu clock mode select block
// Assumes: strap code is three bits, msb on the highest strap pin
// Notes:   none
`ifndef CCMS_REGS_SVH
`define CCMS_REGS_SVH
`define CCMS_STRAP_W        3
`define CCMS_OWD_DIS_BIT    4
`define CCMS_SYSCFG_W       16
`define CCMS_SYSCFG_RST     16'h0000
`define CCMS_CODE_X4        3'h7
`define CCMS_CODE_X3        3'h6
`define CCMS_CODE_X8        3'h5
`define CCMS_CODE_X5        3'h4
`define CCMS_CODE_DIRECT    3'h3
`define CCMS_CODE_X10       3'h2
`define CCMS_CODE_PRESCALE  3'h1
`define CCMS_CODE_X16       3'h0
`define CCMS_STRAP_RST      3'h7
`define CCMS_MULT_W         5
`endif

// ==== rtl/ccms_pkg.sv ====
// Purpose: types for the cpu clock mode select block
// Assumes: nothing
// Notes:   mode kinds only; numbers live in ccms_regs.svh
package ccms_pkg;
    typedef enum logic [1:0] {
        CCMS_MODE_PLL,
        CCMS_MODE_DIRECT,
        CCMS_MODE_PRESCALE
    } ccms_mode_t;
endpackage

// ==== rtl/ccms_prescaler.sv ====
// Purpose: 2:1 divider of the oscillator clock for prescaler mode
// Assumes: runs on the input clock itself
// Notes:   toggles every rising input edge, so duty cycle of the input does not matter
`include "ccms_regs.svh"
module ccms_prescaler (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // control
    input  wire logic enable,
    // output
    output logic      clk_div2
);
    logic div_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_q <= 1'b0;
        end else if (enable) begin
            div_q <= ~div_q;
        end else begin
            div_q <= 1'b0;
        end
    end

    assign clk_div2 = div_q;

    a_phase_len: assert property (@(posedge mclk) disable iff (rst)
        $past(enable) && enable |-> div_q != $past(div_q))
        else $error("prescaler phase not one input period");
endmodule

// ==== rtl/ccms_top.sv ====
// Purpose: capture clock mode straps at reset and steer cpu clock generation
// Assumes: mclk is the oscillator/input clock; pll analog lives outside
// Notes:   mode fixed until next reset
// Operation
// - straps sampled on the first mclk edge after reset release choose clock generation mechanism
// - code maps to x4,x3,x8,x5,x10,x16,x1 or divide by two
// - oscillator amplifier bypassed only in direct drive mode
// - code 001 gives cpu clock through 2:1 prescaler, half frequency
// - prescaler high and low phases each last one input period
// - prescaler mode: pll free-runs for watchdog unless disable bit set
// - both cpu clock edges usable; phase time is edge to edge interval
// - code 011 bypasses amplifier, drives clock from input; pll free-runs unless watchdog disable bit set
// - watchdog disable is config bit 4, cleared at reset
`include "ccms_regs.svh"
module ccms_top
    import ccms_pkg::*;
#(
    parameter int MULT_W = `CCMS_MULT_W
) (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // board straps
    input  wire logic [`CCMS_STRAP_W-1:0]   clock_mode_straps,
    // system configuration write port
    input  wire logic                       cfg_we,
    input  wire logic [`CCMS_SYSCFG_W-1:0]  cfg_wdata,
    output logic [`CCMS_SYSCFG_W-1:0]       system_config_register,
    // clock generation controls
    output logic [`CCMS_STRAP_W-1:0]        clock_mode_strap_bits,
    output ccms_pkg::ccms_mode_t            clk_mode,
    output logic [MULT_W-1:0]               pll_mult,
    output logic                            pll_enable,
    output logic                            pll_free_run,
    output logic                            osc_amp_enable,
    output logic                            osc_bypass,
    output logic                            cpu_clk,
    output logic                            cpu_clk_edge
);
    import ccms_pkg::*;

    logic [`CCMS_STRAP_W-1:0]  strap_q;
    logic                      in_rst_q;
    logic [`CCMS_SYSCFG_W-1:0] cfg_q;
    logic                      osc_watchdog_disable;
    logic                      pre_clk;
    logic                      cpu_clk_q;
    ccms_mode_t                mode_d;
    logic [MULT_W-1:0]         mult_d;

    // reset marker: first clocked cycle after release still samples straps
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_rst_q <= 1'b1;
        end else begin
            in_rst_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap_q <= `CCMS_STRAP_RST;
        end else if (in_rst_q) begin
            strap_q <= clock_mode_straps;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_q <= `CCMS_SYSCFG_RST;
        end else if (cfg_we) begin
            cfg_q <= cfg_wdata;
        end
    end
    assign osc_watchdog_disable   = cfg_q[`CCMS_OWD_DIS_BIT];
    assign system_config_register = cfg_q;

    always_comb begin
        mode_d = CCMS_MODE_PLL;
        mult_d = MULT_W'(4);
        case (strap_q)
            `CCMS_CODE_X4:       mult_d = MULT_W'(4);
            `CCMS_CODE_X3:       mult_d = MULT_W'(3);
            `CCMS_CODE_X8:       mult_d = MULT_W'(8);
            `CCMS_CODE_X5:       mult_d = MULT_W'(5);
            `CCMS_CODE_X10:      mult_d = MULT_W'(10);
            `CCMS_CODE_X16:      mult_d = MULT_W'(16);
            `CCMS_CODE_DIRECT: begin
                mode_d = CCMS_MODE_DIRECT;
                mult_d = MULT_W'(1);
            end
            `CCMS_CODE_PRESCALE: begin
                mode_d = CCMS_MODE_PRESCALE;
                mult_d = MULT_W'(1);
            end
            default:             mult_d = MULT_W'(4);
        endcase
    end

    assign clk_mode              = mode_d;
    assign pll_mult              = mult_d;
    assign clock_mode_strap_bits = strap_q;

    assign osc_bypass     = (mode_d == CCMS_MODE_DIRECT);
    assign osc_amp_enable = ~osc_bypass;

    // pll free-run for watchdog
    // pll off in non-multiplying modes when the watchdog is disabled
    assign pll_free_run = (mode_d != CCMS_MODE_PLL) & ~osc_watchdog_disable;
    assign pll_enable   = (mode_d == CCMS_MODE_PLL) | pll_free_run;

    ccms_prescaler u_pre (
        .mclk     (mclk),
        .rst      (rst),
        .enable   (mode_d == CCMS_MODE_PRESCALE),
        .clk_div2 (pre_clk)
    );

    // registered cpu clock view; pll modes route the pll output outside
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_clk_q <= 1'b0;
        end else begin
            cpu_clk_q <= (mode_d == CCMS_MODE_PRESCALE) ? pre_clk : 1'b0;
        end
    end
    assign cpu_clk = cpu_clk_q;

    // both edges marked
    // high in the input cycle before every cpu clock transition, rising or falling
    assign cpu_clk_edge = (mode_d == CCMS_MODE_PRESCALE) & (pre_clk != cpu_clk_q);

    a_strap_hold: assert property (@(posedge mclk) disable iff (rst)
        !$past(in_rst_q) |-> $stable(strap_q))
        else $error("strap code changed after reset");
    a_strap_cap: assert property (@(posedge mclk) disable iff (rst)
        in_rst_q |=> strap_q == $past(clock_mode_straps))
        else $error("strap not captured at release");
    a_direct_drv: assert property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_DIRECT |-> osc_bypass && !osc_amp_enable
            && pll_mult == MULT_W'(1) && !(pll_enable && osc_watchdog_disable))
        else $error("direct drive controls wrong");
    a_amp_on: assert property (@(posedge mclk) disable iff (rst)
        strap_q != `CCMS_CODE_DIRECT |-> osc_amp_enable)
        else $error("amplifier off outside direct drive");
    a_pll_owd: assert property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_PRESCALE |-> pll_enable == !cfg_q[`CCMS_OWD_DIS_BIT])
        else $error("pll state wrong in prescaler mode");
    a_mult_map: assert property (@(posedge mclk) disable iff (rst)
        (strap_q == `CCMS_CODE_X16 |-> pll_mult == MULT_W'(16)) and
        (strap_q == `CCMS_CODE_X10 |-> pll_mult == MULT_W'(10)) and
        (strap_q == `CCMS_CODE_X3  |-> pll_mult == MULT_W'(3)))
        else $error("multiplier decode wrong");
    a_half_rate: assert property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_PRESCALE && $past(strap_q) == `CCMS_CODE_PRESCALE
            ##1 strap_q == `CCMS_CODE_PRESCALE |-> pre_clk == $past(pre_clk, 2))
        else $error("prescaler not divide by two");
    a_owd_bit: assert property (@(posedge mclk) disable iff (rst)
        cfg_we |=> system_config_register[`CCMS_OWD_DIS_BIT]
            == $past(cfg_wdata[`CCMS_OWD_DIS_BIT]))
        else $error("watchdog disable bit not stored");
    a_edge_mark: assert property (@(posedge mclk) disable iff (rst)
        cpu_clk_edge |=> cpu_clk != $past(cpu_clk))
        else $error("edge mark without cpu clock change");

    a_mult_rest: assert property (@(posedge mclk) disable iff (rst)
        (strap_q == `CCMS_CODE_X4 |-> pll_mult == MULT_W'(4)) and
        (strap_q == `CCMS_CODE_X8 |-> pll_mult == MULT_W'(8)) and
        (strap_q == `CCMS_CODE_X5 |-> pll_mult == MULT_W'(5)) and
        (strap_q == `CCMS_CODE_PRESCALE |-> pll_mult == MULT_W'(1)))
        else $error("multiplier decode wrong for remaining codes");
    a_free_run: assert property (@(posedge mclk) disable iff (rst)
        pll_free_run |-> clk_mode != CCMS_MODE_PLL && !osc_watchdog_disable)
        else $error("pll free-runs in multiplying mode or with watchdog off");
    a_clk_idle: assert property (@(posedge mclk) disable iff (rst)
        clk_mode != CCMS_MODE_PRESCALE |=> !cpu_clk)
        else $error("cpu clock toggles outside prescaler mode");
    a_edge_idle: assert property (@(posedge mclk) disable iff (rst)
        clk_mode != CCMS_MODE_PRESCALE |-> !cpu_clk_edge)
        else $error("edge mark outside prescaler mode");
    a_cpu_phase: assert property (@(posedge mclk) disable iff (rst)
        cpu_clk_edge |=> cpu_clk_edge)
        else $error("cpu clock phase longer than one input period");
    a_cfg_rst: assert property (@(posedge mclk) disable iff (rst)
        in_rst_q |-> system_config_register == `CCMS_SYSCFG_RST)
        else $error("config register not cleared by reset");
    a_cfg_hold: assert property (@(posedge mclk) disable iff (rst)
        !cfg_we |=> $stable(system_config_register))
        else $error("config register changed without a write");

    // main scenarios: direct, prescaler, x16, free-run, config write
    c_direct:   cover property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_DIRECT);
    c_prescale: cover property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_PRESCALE && osc_watchdog_disable);
    c_x16:      cover property (@(posedge mclk) disable iff (rst)
        strap_q == `CCMS_CODE_X16);
    c_free_run: cover property (@(posedge mclk) disable iff (rst)
        pll_free_run);
    c_cfg_wr:   cover property (@(posedge mclk) disable iff (rst)
        cfg_we);
endmodule

// ==== bench/ccms_osc_model.sv ====
// Purpose: input clock source in front of the clock mode select block
// Assumes: crystal oscillator at 25 MHz, running free
// Notes:   board straps are driven by the bench itself
module ccms_osc_model (
    // clock out
    output logic mclk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;
endmodule

// ==== bench/cpu_clock_mode_select_tb.sv ====
// Purpose: self-checking bench for the cpu clock mode select block
// Assumes: inputs change at the falling edge of mclk
// Notes:   every strap code is booted at least once; only the prescaler makes cpu_clk
`include "ccms_regs.svh"
module cpu_clock_mode_select_tb import ccms_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, cfg_we, pll_enable, pll_free_run, osc_amp_enable;
    logic osc_bypass, cpu_clk, cpu_clk_edge;
    logic [2:0] clock_mode_straps, clock_mode_strap_bits;
    logic [15:0] cfg_wdata, system_config_register;
    logic [4:0] pll_mult;
    ccms_mode_t clk_mode;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    // expected factor, indexed by strap code
    logic [4:0] mt [8] = '{5'h10, 5'h01, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
    ccms_osc_model osc (.mclk(mclk));
    ccms_top dut (.mclk(mclk), .rst(rst), .clock_mode_straps(clock_mode_straps),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .system_config_register(system_config_register),
        .clock_mode_strap_bits(clock_mode_strap_bits), .clk_mode(clk_mode),
        .pll_mult(pll_mult), .pll_enable(pll_enable), .pll_free_run(pll_free_run),
        .osc_amp_enable(osc_amp_enable), .osc_bypass(osc_bypass), .cpu_clk(cpu_clk),
        .cpu_clk_edge(cpu_clk_edge));
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic boot(input logic [2:0] c);
        @(negedge mclk) rst = 1'b1;
        clock_mode_straps = c;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic cfg_write(input logic [15:0] d);
        cfg_we = 1'b1;
        cfg_wdata = d;
        @(negedge mclk) cfg_we = 1'b0;
        @(negedge mclk);
    endtask
    task automatic check_mode(input logic [2:0] c, input logic dis);
        ccms_mode_t md;
        md = (c == 3'h3) ? CCMS_MODE_DIRECT : (c == 3'h1) ? CCMS_MODE_PRESCALE : CCMS_MODE_PLL;
        chk("strap_bits", 16'(clock_mode_strap_bits), 16'(c));
        chk("pll_mult", 16'(pll_mult), 16'(mt[c]));
        chk("clk_mode", 16'(clk_mode), 16'(md));
        chk("osc_amp_enable", 16'(osc_amp_enable), 16'(c != 3'h3));
        chk("osc_bypass", 16'(osc_bypass), 16'(c == 3'h3));
        chk("pll_enable", 16'(pll_enable), 16'(md == CCMS_MODE_PLL || !dis));
        chk("pll_free_run", 16'(pll_free_run), 16'(md != CCMS_MODE_PLL && !dis));
        if (c != 3'h1) begin
            chk("cpu_clk", 16'(cpu_clk), 16'h0000);
            chk("cpu_clk_edge", 16'(cpu_clk_edge), 16'h0000);
        end
    endtask
    task automatic test_codes();
        for (int c = 0; c < 8; c++) begin
            boot(3'(c));
            check_mode(3'(c), 1'b0);
            chk("cfg_reset", system_config_register, 16'h0000);
            clock_mode_straps = ~3'(c);
            repeat (3) @(negedge mclk);
            check_mode(3'(c), 1'b0);
        end
        $display("test codes done");
    endtask
    task automatic test_owd();
        logic [2:0] cs [3] = '{3'h1, 3'h3, 3'h7};
        foreach (cs[i]) begin
            boot(cs[i]);
            cfg_write(16'h0010);
            chk("cfg_bit4", system_config_register, 16'h0010);
            check_mode(cs[i], 1'b1);
            cfg_write(16'hffef);
            chk("cfg_back", system_config_register, 16'hffef);
            check_mode(cs[i], 1'b0);
        end
        $display("test watchdog disable done");
    endtask
    task automatic test_prescale();
        logic prev;
        boot(3'h1);
        prev = cpu_clk;
        repeat (8) begin
            @(negedge mclk);
            chk("cpu_clk_phase", 16'(cpu_clk), prev ? 16'h0000 : 16'h0001);
            chk("cpu_clk_edge", 16'(cpu_clk_edge), 16'h0001);
            prev = cpu_clk;
        end
        $display("test prescale done");
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        clock_mode_straps = 3'h7;
        cfg_we = 1'b0;
        cfg_wdata = 16'h0000;
        test_codes();
        test_owd();
        test_prescale();
        give_verdict();
    end
endmodule
